//--- src/dtct_pkg.sv
package dtct_pkg;

  // oscillator divider feeding both counters
  localparam int unsigned OSC_DIV       = 32;
  localparam int unsigned PRE_W         = $clog2(OSC_DIV);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(OSC_DIV - 1);
  localparam logic [PRE_W-1:0] PRE_RST  = '0;

  // fixed timebase counter
  localparam logic [7:0] CNT1_TOP = 8'hF9;
  localparam logic [7:0] CNT1_RST = 8'h00;

  // auto-reload counter
  localparam logic [7:0] CNT2_TOP = 8'hFF;
  localparam logic [7:0] CNT2_RST = 8'h00;
  localparam logic [7:0] RELOAD_RST = 8'h00;

  // capture register
  localparam logic [7:0] CAP_RST = 8'h00;

  // cycles of the block clock between fixed timebase ticks
  localparam int unsigned TICK1_CYCLES = OSC_DIV * (int'(CNT1_TOP) + 1);

  // capture flag state right after reset (undefined in hardware)
  localparam logic CAP_FLAG_RST = 1'b0;

  typedef struct packed {
    logic tick1;
    logic tick2;
    logic capture;
  } dtct_events_t;

  typedef struct packed {
    logic tick1;
    logic tick2;
    logic capture;
  } dtct_enables_t;

  typedef struct packed {
    logic wait_mode;
    logic active_halt_mode;
    logic halt_mode;
  } dtct_power_t;

endpackage

//--- src/dtct_timer.sv
`timescale 1ns/1ns
// What this block does
// R1: hidden fixed counter counts up from zero
// R2: fixed counter wraps F9h to 00h, overflow
// R3: period select bit doubles fixed tick period
// R4: fixed overflow sets tick1 flag, gated irq
// R5: reading first status register clears tick1 flag
// R6: readable reload counter starts from reload value
// R7: reload counter reloads after FFh overflow
// R8: reload writes take effect at next overflow
// R9: reload overflow sets tick2 flag, gated irq
// R10: reading second status register clears tick2 flag
// R11: reload period programmable in 256 steps
// R12: pin edge latches fixed count, sets flag
// R13: capture irq gated; capture read clears flag
// R14: no capture update while capture flag set
// R15: halt stops counters; other modes ignored
// R16: three separate gated interrupt request lines
// R17: software reads capture once after reset
// R18: tick1 wakes wait/active-halt; others only wait
module dtct_timer (
  input  wire logic                  sys_clk,
  input  wire logic                  sys_rst,
  input  wire dtct_pkg::dtct_power_t power_mode,
  input  wire logic                  period_double_sel,
  input  wire dtct_pkg::dtct_enables_t irq_en,
  input  wire logic                  reload_wr,
  input  wire logic [7:0]            reload_wdata,
  input  wire logic                  rd_first_ctrl_status,
  input  wire logic                  rd_second_ctrl_status,
  input  wire logic                  rd_capture_value,
  input  wire logic                  capture_pin,
  output logic [7:0]                 reload_value_reg,
  output logic [7:0]                 reload_counter_reg,
  output logic [7:0]                 capture_value_reg,
  output dtct_pkg::dtct_events_t     flags,
  output dtct_pkg::dtct_events_t     irq_req,
  output logic                       wake_req
);

  logic [dtct_pkg::PRE_W-1:0] pre_r;
  logic                       tick_en;
  logic [7:0]                 cnt1_r;
  logic                       half_r;
  logic                       cnt1_wrap;
  logic                       cnt2_wrap;
  dtct_pkg::dtct_events_t     evt;
  dtct_pkg::dtct_events_t     flags_nxt;
  logic                       cap_s1_r;
  logic                       cap_s2_r;
  logic                       cap_s3_r;
  logic                       cap_edge;

  // prescaler: one enable every OSC_DIV clocks, frozen in halt
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pre_r <= dtct_pkg::PRE_RST;
    end else if (!power_mode.halt_mode) begin // see R15
      pre_r <= (pre_r == dtct_pkg::PRE_LAST) ? dtct_pkg::PRE_RST : pre_r + 1'b1;
    end
  end

  assign tick_en = (pre_r == dtct_pkg::PRE_LAST) && !power_mode.halt_mode; // see R15

  // fixed timebase counter, not visible outside
  assign cnt1_wrap = tick_en && (cnt1_r == dtct_pkg::CNT1_TOP); // see R2

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cnt1_r <= dtct_pkg::CNT1_RST; // see R1
    end else if (tick_en) begin
      cnt1_r <= cnt1_wrap ? dtct_pkg::CNT1_RST : cnt1_r + 8'h01; // see R1
    end
  end

  // every second wrap is a tick when the period is doubled
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      half_r <= 1'b0;
    end else if (cnt1_wrap) begin
      half_r <= ~half_r; // see R3
    end
  end

  assign evt.tick1 = cnt1_wrap && (!period_double_sel || half_r); // see R3

  // reload value register, written by software at any time
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      reload_value_reg <= dtct_pkg::RELOAD_RST;
    end else if (reload_wr) begin
      reload_value_reg <= reload_wdata; // see R8
    end
  end

  // auto-reload counter; period is 256 minus reload value enables
  assign cnt2_wrap = tick_en && (reload_counter_reg == dtct_pkg::CNT2_TOP); // see R7

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      reload_counter_reg <= dtct_pkg::CNT2_RST; // see R6
    end else if (cnt2_wrap) begin
      reload_counter_reg <= reload_value_reg; // see R7 see R8 see R11
    end else if (tick_en) begin
      reload_counter_reg <= reload_counter_reg + 8'h01; // see R6
    end
  end

  assign evt.tick2 = cnt2_wrap; // see R9

  // capture pin synchroniser and edge detect
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cap_s1_r <= 1'b0;
      cap_s2_r <= 1'b0;
      cap_s3_r <= 1'b0;
    end else begin
      cap_s1_r <= capture_pin;
      cap_s2_r <= cap_s1_r;
      cap_s3_r <= cap_s2_r;
    end
  end

  assign cap_edge    = cap_s2_r ^ cap_s3_r; // see R12
  assign evt.capture = cap_edge && !flags.capture; // see R14

  // capture register holds the last accepted capture
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      capture_value_reg <= dtct_pkg::CAP_RST;
    end else if (evt.capture) begin
      capture_value_reg <= cnt1_r; // see R12 see R14
    end
  end

  // sticky flags; a set in the clearing cycle wins
  always_comb begin
    flags_nxt = flags;
    if (rd_first_ctrl_status) begin
      flags_nxt.tick1 = 1'b0; // see R5
    end
    if (rd_second_ctrl_status) begin
      flags_nxt.tick2 = 1'b0; // see R10
    end
    if (rd_capture_value) begin
      flags_nxt.capture = 1'b0; // see R13
    end
    if (evt.tick1) begin
      flags_nxt.tick1 = 1'b1; // see R4
    end
    if (evt.tick2) begin
      flags_nxt.tick2 = 1'b1; // see R9
    end
    if (evt.capture) begin
      flags_nxt.capture = 1'b1; // see R12
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      flags <= '{tick1: 1'b0, tick2: 1'b0, capture: dtct_pkg::CAP_FLAG_RST}; // see R17
    end else begin
      flags <= flags_nxt;
    end
  end

  // separate request lines, each gated by its enable
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irq_req <= '0;
    end else begin
      irq_req.tick1   <= flags_nxt.tick1 && irq_en.tick1; // see R4 see R16
      irq_req.tick2   <= flags_nxt.tick2 && irq_en.tick2; // see R9 see R16
      irq_req.capture <= flags_nxt.capture && irq_en.capture; // see R13 see R16
    end
  end

  // wake-up: tick1 from wait or active-halt, the others from wait only
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wake_req <= 1'b0;
    end else begin
      wake_req <= (power_mode.wait_mode &&
                   ((flags_nxt.tick1 && irq_en.tick1) ||
                    (flags_nxt.tick2 && irq_en.tick2) ||
                    (flags_nxt.capture && irq_en.capture))) ||
                  (power_mode.active_halt_mode &&
                   flags_nxt.tick1 && irq_en.tick1); // see R18
    end
  end

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  a_prescale_gap: assert property (tick_en |=> !tick_en [*8]) // see R1
    else $error("prescaler enable came too soon");

  a_cnt1_wrap: assert property (cnt1_wrap |=> cnt1_r == 8'h00) // see R2
    else $error("fixed counter did not wrap to zero");

  a_cnt1_range: assert property (cnt1_r <= 8'hF9) // see R2
    else $error("fixed counter passed its top");

  a_halt_freeze: assert property (power_mode.halt_mode |=> // see R15
                                  $stable(cnt1_r) && $stable(reload_counter_reg))
    else $error("counter moved in halt");

  a_tick_double: assert property ((evt.tick1 && period_double_sel) |=> // see R3
                                  !evt.tick1 [*8])
    else $error("doubled tick came too soon");

  a_tick1_set: assert property (evt.tick1 |=> flags.tick1) // see R4
    else $error("tick1 flag not set");

  a_tick1_clear: assert property ((rd_first_ctrl_status && !evt.tick1) |=> !flags.tick1) // see R5
    else $error("tick1 flag not cleared by read");

  a_cnt2_reload: assert property (cnt2_wrap |=> // see R7
                                  reload_counter_reg == $past(reload_value_reg))
    else $error("reload counter did not reload");

  a_cnt2_step: assert property ((tick_en && !cnt2_wrap) |=> // see R6
                                reload_counter_reg == $past(reload_counter_reg) + 8'h01)
    else $error("reload counter did not step");

  a_tick2_set: assert property (evt.tick2 |=> flags.tick2) // see R9
    else $error("tick2 flag not set");

  a_tick2_clear: assert property ((rd_second_ctrl_status && !evt.tick2) |=> // see R10
                                  !flags.tick2)
    else $error("tick2 flag not cleared by read");

  a_cap_latch: assert property ((cap_edge && !flags.capture) |=> // see R12
                                capture_value_reg == $past(cnt1_r) && flags.capture)
    else $error("capture not latched");

  a_cap_hold: assert property ((flags.capture && !rd_capture_value) |=> // see R14
                               $stable(capture_value_reg) && flags.capture)
    else $error("capture changed while flag set");

  a_cap_clear: assert property ((rd_capture_value && !evt.capture) |=> !flags.capture) // see R13
    else $error("capture flag not cleared by read");

  a_irq_gate: assert property (irq_req.tick2 |-> flags.tick2 && $past(irq_en.tick2)) // see R16
    else $error("tick2 request without flag and enable");

  a_wake_ahalt: assert property ((power_mode.active_halt_mode && // see R18
                                  !power_mode.wait_mode && !irq_en.tick1) |=> !wake_req)
    else $error("wake from active-halt without tick1");

  a_cnt1_step: assert property ((tick_en && !cnt1_wrap) |=> // see R1
                                cnt1_r == $past(cnt1_r) + 8'h01)
    else $error("fixed counter did not step");

  a_cnt_idle: assert property (!tick_en |=> // see R15
                               $stable(cnt1_r) && $stable(reload_counter_reg))
    else $error("counter moved without enable");

  a_reload_write: assert property (reload_wr |=> // see R8
                                   reload_value_reg == $past(reload_wdata))
    else $error("reload value not written");

  a_reload_keep: assert property (!reload_wr |=> $stable(reload_value_reg)) // see R8
    else $error("reload value changed without write");

  a_tick2_source: assert property (reload_counter_reg != dtct_pkg::CNT2_TOP |-> // see R7
                                   !evt.tick2)
    else $error("tick2 without counter at top");

  a_tick1_hold: assert property ((flags.tick1 && !rd_first_ctrl_status) |=> // see R4
                                 flags.tick1)
    else $error("tick1 flag lost without read");

  a_tick2_hold: assert property ((flags.tick2 && !rd_second_ctrl_status) |=> // see R9
                                 flags.tick2)
    else $error("tick2 flag lost without read");

  a_tick1_irq: assert property ((evt.tick1 && irq_en.tick1) |=> irq_req.tick1) // see R4
    else $error("tick1 request missing");

  a_tick2_irq: assert property ((evt.tick2 && irq_en.tick2) |=> irq_req.tick2) // see R9
    else $error("tick2 request missing");

  a_cap_irq: assert property ((evt.capture && irq_en.capture) |=> irq_req.capture) // see R13
    else $error("capture request missing");

  a_irq_mask: assert property ((!irq_en.tick1 && !irq_en.tick2 && !irq_en.capture) |=> // see R16
                               !irq_req.tick1 && !irq_req.tick2 && !irq_req.capture)
    else $error("request raised while all enables off");

  a_wake_wait: assert property ((power_mode.wait_mode && flags.tick2 && irq_en.tick2 && // see R18
                                !rd_second_ctrl_status) |=> wake_req)
    else $error("wait mode not left on tick2");

  a_wake_tick1: assert property ((power_mode.active_halt_mode && flags.tick1 && // see R18
                                 irq_en.tick1 && !rd_first_ctrl_status) |=> wake_req)
    else $error("active-halt not left on tick1");

  a_wake_quiet: assert property ((!power_mode.wait_mode && // see R18
                                 !power_mode.active_halt_mode) |=> !wake_req)
    else $error("wake raised outside low-power modes");

  c_capture: cover property (evt.capture ##1 rd_capture_value);
  c_doubled: cover property (period_double_sel && evt.tick1);
  c_reload: cover property (reload_wr ##[1:300] cnt2_wrap);
  c_wake: cover property (power_mode.wait_mode && wake_req);
  c_ahalt: cover property (power_mode.active_halt_mode && wake_req);

endmodule

//--- tb/dtct_partner.sv
`timescale 1ns/1ns
// capture pin source: one request pulse gives one pin edge
module dtct_partner (
  input  wire logic sys_clk,
  input  wire logic edge_req,
  output logic      capture_pin
);
  logic go_r = 1'b0;
  initial capture_pin = 1'b0;
  always @(posedge sys_clk) go_r <= edge_req;
  // both edge directions are produced in turn
  always @(negedge sys_clk) if (go_r) capture_pin <= ~capture_pin;
endmodule

//--- tb/dual_timebase_capture_timer_tb_top.sv
`timescale 1ns/1ns
module dual_timebase_capture_timer_tb_top;
  logic                   sys_clk  = 1'b0;
  logic                   sys_rst  = 1'b1;
  dtct_pkg::dtct_power_t  pm       = 3'h0;
  dtct_pkg::dtct_enables_t ien     = 3'h7;
  logic                   dbl      = 1'b0;
  logic                   rwr      = 1'b0;
  logic                   edge_req = 1'b0;
  logic [7:0]             rwd      = 8'h00;
  logic [2:0]             rdv      = 3'h0;
  logic                   cpin;
  logic [7:0]             rv;
  logic [7:0]             rc;
  logic [7:0]             cv;
  logic [7:0]             snap;
  dtct_pkg::dtct_events_t fl;
  dtct_pkg::dtct_events_t irq;
  logic                   wk;
  int                     err_total    = 0;
  int                     total_checks = 0;
  int                     cyc          = 0;
  int                     t1;

  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= sys_rst ? 0 : cyc + 1;
  always @(posedge sys_clk) if (cyc > 60000) begin
    err_total++;
    conclude();
  end

  dtct_timer i_dtct_timer (.sys_clk(sys_clk), .sys_rst(sys_rst), .power_mode(pm),
    .period_double_sel(dbl), .irq_en(ien), .reload_wr(rwr), .reload_wdata(rwd),
    .rd_first_ctrl_status(rdv[0]), .rd_second_ctrl_status(rdv[1]),
    .rd_capture_value(rdv[2]), .capture_pin(cpin), .reload_value_reg(rv),
    .reload_counter_reg(rc), .capture_value_reg(cv), .flags(fl), .irq_req(irq),
    .wake_req(wk));
  dtct_partner i_dtct_partner (.sys_clk(sys_clk), .edge_req(edge_req), .capture_pin(cpin));

  task conclude;
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task cyc_n(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task til(input int c);
    while (cyc < c) @(negedge sys_clk);
  endtask
  task wait_fl(input int b);
    int k;
    k = 0;
    while (fl[b] !== 1'b1 && k < 20000) begin
      @(negedge sys_clk);
      k++;
    end
    if (k >= 20000) err_total++;
  endtask
  task rd(input int b);
    rdv[b] = 1'b1;
    @(negedge sys_clk);
    rdv = 3'h0;
  endtask
  task pin_edge;
    edge_req = 1'b1;
    @(negedge sys_clk);
    edge_req = 1'b0;
  endtask

  task t_reset;
    chk({rv, rc, cv}, 24'h000000);
    chk({fl, irq, wk}, 7'h00);
  endtask
  task t_capture;
    rd(2);
    til(328);
    pin_edge();
    wait_fl(0);
    chk(cv, 8'h0A);
    chk(irq[0], 1'b1);
    pin_edge();
    cyc_n(10);
    chk(cv, 8'h0A);
    rd(2);
    chk(fl[0], 1'b0);
  endtask
  task t_tick1;
    wait_fl(2);
    chk(cyc, dtct_pkg::TICK1_CYCLES);
    chk(irq[2], 1'b1);
    rd(0);
    chk(fl[2], 1'b0);
  endtask
  task t_reload;
    til(8100);
    rwd = 8'hF0;
    rwr = 1'b1;
    @(negedge sys_clk);
    rwr = 1'b0;
    chk({rv, rc}, 16'hF0FD);
    wait_fl(1);
    chk(cyc, 8192);
    chk(rc, 8'hF0);
    chk(irq[1], 1'b1);
    rd(1);
    chk(fl[1], 1'b0);
    wait_fl(1);
    chk(cyc, 8704);
  endtask
  task t_double;
    dbl = 1'b1;
    wait_fl(2);
    t1 = cyc;
    rd(0);
    wait_fl(2);
    chk(cyc - t1, 2 * dtct_pkg::TICK1_CYCLES);
    dbl = 1'b0;
  endtask
  task t_power;
    ien = 3'h0;
    pm = 3'h4;
    cyc_n(2);
    chk({irq, wk}, 4'h0);
    ien = 3'h7;
    cyc_n(2);
    chk({irq, wk}, 4'hD);
    pm = 3'h2;
    cyc_n(2);
    chk(wk, 1'b1);
    ien = 3'h3;
    cyc_n(2);
    chk(wk, 1'b0);
    ien = 3'h7;
    rd(0);
    pin_edge();
    wait_fl(0);
    cyc_n(2);
    chk(wk, 1'b0);
    pm = 3'h1;
    cyc_n(2);
    snap = rc;
    cyc_n(100);
    chk(rc, snap);
    pm = 3'h4;
    cyc_n(70);
    chk(rc !== snap, 1'b1);
  endtask

  initial begin
    cyc_n(4);
    sys_rst = 1'b0;
    @(negedge sys_clk);
    t_reset();
    t_capture();
    t_tick1();
    t_reload();
    t_double();
    t_power();
    conclude();
  end
endmodule
